/* rtl/slot_a_afe_config_regs.sv */
// apb register bank and window timing for the slot a analog front end
`default_nettype none
module slot_a_afe_config_regs
#(
	parameter int ADDR_W = 12  // apb address width
)
(
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_W-1:0]      paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic                        pready,
	output var  logic [31:0]            prdata,
	output logic                        pslverr,
	// slot timing core
	input  wire logic                   slot_start,
	input  wire logic                   pulse_start,
	output var  logic                   window_open,
	output var  logic                   pulse_reverse,
	output var  logic [1:0]             pulse_index,
	// analog front-end configuration
	output var  afe_cfg_pkg::afe_cfg_s  afe_cfg
);

	// the highest register needs nine address bits
	if (ADDR_W < 9)
	begin : g_addr_check
		$error("slot_a_afe_config_regs: ADDR_W must be at least 9");
	end

	localparam int CNT_W = 14;  // covers the longest delay and width

	typedef enum {st_idle, st_delay, st_open} win_state_e;

	logic [15:0]      integration_order;   // slot_a_integration_order
	logic [15:0]      integration_window;  // slot_a_integration_window
	logic [15:0]      frontend_control;    // slot_a_frontend_control
	logic [15:0]      channel_gains;       // slot_a_channel_gains
	logic             hit_order;           // address decode strobes
	logic             hit_window;
	logic             hit_control;
	logic             hit_gains;
	logic             mapped;              // any register addressed
	logic             wr_access;           // write takes effect this edge
	logic [15:0]      lane_mask;           // written bits from pstrb
	logic [15:0]      read_word;           // selected register
	logic             individual_enable;   // own channel gains in use
	logic [1:0]       common_gain;         // shared slot gain
	logic [1:0]       intg_code;           // integrator gain code
	logic             int_buffer;          // integrator as buffer
	logic [CNT_W-1:0] delay_cycles;        // window delay in clock cycles
	logic [CNT_W-1:0] width_cycles;        // window width in clock cycles
	logic [CNT_W-1:0] win_cnt;             // cycles left in current phase
	win_state_e       win_state;           // window timer state

	// true when the address names the given register index
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		addr_is = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
	endfunction

	// channel gain: own field when individual gains are on, else the shared one
	function automatic logic [1:0] pick_gain(input logic ind, input logic [1:0] own,
		input logic [1:0] shared);
		pick_gain = ind ? own : shared;
	endfunction

	// delay field to cycles, rounded up so the window never opens early
	function automatic logic [CNT_W-1:0] delay_to_cycles(input logic [10:0] steps);
		int ps;
		ps = int'(steps) * afe_cfg_pkg::DELAY_STEP_PS;
		delay_to_cycles = CNT_W'((ps + afe_cfg_pkg::CLK_PERIOD_PS - 1)
			/ afe_cfg_pkg::CLK_PERIOD_PS);
	endfunction

	// address decode
	always_comb
	begin
		hit_order   = addr_is(paddr, afe_cfg_pkg::IDX_ORDER);
		hit_window  = addr_is(paddr, afe_cfg_pkg::IDX_WINDOW);
		hit_control = addr_is(paddr, afe_cfg_pkg::IDX_CONTROL);
		hit_gains   = addr_is(paddr, afe_cfg_pkg::IDX_GAINS);
		mapped      = hit_order | hit_window | hit_control | hit_gains;
		wr_access   = psel & penable & pwrite & mapped;
		lane_mask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	end

	// zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// read mux; unmapped reads return zero
	always_comb
	begin
		if (hit_order)
			read_word = integration_order;
		else if (hit_window)
			read_word = integration_window;
		else if (hit_control)
			read_word = frontend_control;
		else if (hit_gains)
			read_word = channel_gains;
		else
			read_word = 16'h0000;
	end

	// read data is captured in the setup cycle and stands through the access
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {16'h0000, read_word};
	end

	// pattern register; reserved bits are held at zero
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			integration_order <= afe_cfg_pkg::ORDER_RST;
		else if (wr_access && hit_order)
			integration_order <= ((pwdata[15:0] & lane_mask) | (integration_order & ~lane_mask))
				& afe_cfg_pkg::ORDER_MASK;
	end

	// window width and delay register
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			integration_window <= afe_cfg_pkg::WINDOW_RST;
		else if (wr_access && hit_window)
			integration_window <= ((pwdata[15:0] & lane_mask) | (integration_window & ~lane_mask))
				& afe_cfg_pkg::WINDOW_MASK;
	end

	// front-end control register; the mode field is stored as written
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			frontend_control <= afe_cfg_pkg::CONTROL_RST;
		else if (wr_access && hit_control)
			frontend_control <= ((pwdata[15:0] & lane_mask) | (frontend_control & ~lane_mask))
				& afe_cfg_pkg::CONTROL_MASK;
	end

	// per-channel gain register
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			channel_gains <= afe_cfg_pkg::GAINS_RST;
		else if (wr_access && hit_gains)
			channel_gains <= ((pwdata[15:0] & lane_mask) | (channel_gains & ~lane_mask))
				& afe_cfg_pkg::GAINS_MASK;
	end

	// field extraction
	always_comb
	begin
		individual_enable = frontend_control[afe_cfg_pkg::IND_BIT];
		common_gain       = frontend_control[afe_cfg_pkg::COMMON_LSB +: 2];
		intg_code         = frontend_control[afe_cfg_pkg::INTG_LSB +: 2];
		int_buffer        = frontend_control[afe_cfg_pkg::BUF_BIT];
		delay_cycles      = delay_to_cycles(
			integration_window[afe_cfg_pkg::DELAY_LSB +: afe_cfg_pkg::DELAY_W]);
		width_cycles      = CNT_W'(int'(
			integration_window[afe_cfg_pkg::WIDTH_LSB +: afe_cfg_pkg::WIDTH_W])
			* afe_cfg_pkg::WIDTH_STEP_CYC);
	end

	// registered front-end configuration
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			afe_cfg <= '0;
		end
		else
		begin
			afe_cfg.frontend_mode     <= frontend_control[afe_cfg_pkg::MODE_LSB +: 6];
			afe_cfg.vref              <= frontend_control[afe_cfg_pkg::VREF_LSB +: 2];
			afe_cfg.ch1_gain          <= common_gain;
			afe_cfg.ch2_gain          <= pick_gain(individual_enable,
				channel_gains[afe_cfg_pkg::CH2_LSB +: 2], common_gain);
			afe_cfg.ch3_gain          <= pick_gain(individual_enable,
				channel_gains[afe_cfg_pkg::CH3_LSB +: 2], common_gain);
			afe_cfg.ch4_gain          <= pick_gain(individual_enable,
				channel_gains[afe_cfg_pkg::CH4_LSB +: 2], common_gain);
			afe_cfg.integrator_buffer <= int_buffer;
			// resistor select only in normal mode; code 3 falls back to 100k
			if (int_buffer)
				afe_cfg.rint_sel <= 3'b000;
			else if (intg_code == afe_cfg_pkg::INTG_400K)
				afe_cfg.rint_sel <= 3'b001;
			else if (intg_code == afe_cfg_pkg::INTG_200K)
				afe_cfg.rint_sel <= 3'b010;
			else
				afe_cfg.rint_sel <= 3'b100;
			// buffer gain 0.7 only for code 2 in buffer mode
			afe_cfg.buffer_gain_low   <= int_buffer && (intg_code == afe_cfg_pkg::INTG_100K);
		end
	end

	// integration window: delay after the pulse, then open for the width
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			win_state   <= st_idle;
			win_cnt     <= '0;
			window_open <= 1'b0;
		end
		else if (pulse_start)
		begin
			// a new pulse restarts the timer
			if (delay_cycles != '0)
			begin
				win_state   <= st_delay;
				win_cnt     <= delay_cycles - CNT_W'(1);
				window_open <= 1'b0;
			end
			else if (width_cycles != '0)
			begin
				win_state   <= st_open;
				win_cnt     <= width_cycles - CNT_W'(1);
				window_open <= 1'b1;
			end
			else
			begin
				win_state   <= st_idle;
				window_open <= 1'b0;
			end
		end
		else
		begin
			unique case (win_state)
				st_idle:
				begin
					window_open <= 1'b0;
				end
				st_delay:
				begin
					// count down the offset, then open if the width allows
					if (win_cnt != '0)
						win_cnt <= win_cnt - CNT_W'(1);
					else if (width_cycles != '0)
					begin
						win_state   <= st_open;
						win_cnt     <= width_cycles - CNT_W'(1);
						window_open <= 1'b1;
					end
					else
						win_state <= st_idle;
				end
				st_open:
				begin
					// hold the window for the width count
					if (win_cnt != '0)
						win_cnt <= win_cnt - CNT_W'(1);
					else
					begin
						win_state   <= st_idle;
						window_open <= 1'b0;
					end
				end
			endcase
		end
	end

	// per-pulse polarity from the pattern register
	polarity_sequencer u_polarity
	(
		.clk_sys       (clk_sys),
		.rstn          (rstn),
		.slot_start    (slot_start),
		.pulse_start   (pulse_start),
		.pattern       (integration_order[afe_cfg_pkg::ORDER_LSB +: 4]),
		.pulse_reverse (pulse_reverse),
		.pulse_index   (pulse_index)
	);

endmodule
`default_nettype wire

/* common/afe_cfg_pkg.sv */
// register map, field layout, reset values and timing constants of the slot a front-end bank
`default_nettype none
package afe_cfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_ORDER       = 8'h17;
	localparam logic [7:0]  IDX_WINDOW      = 8'h39;
	localparam logic [7:0]  IDX_CONTROL     = 8'h42;
	localparam logic [7:0]  IDX_GAINS       = 8'h55;

	// reset values
	localparam logic [15:0] ORDER_RST       = 16'h0000;
	localparam logic [15:0] WINDOW_RST      = 16'h22fc;
	localparam logic [15:0] CONTROL_RST     = 16'h1c38;
	localparam logic [15:0] GAINS_RST       = 16'h0000;

	// bits that hold state; the rest read as zero
	localparam logic [15:0] ORDER_MASK      = 16'h000f;
	localparam logic [15:0] WINDOW_MASK     = 16'hffff;
	localparam logic [15:0] CONTROL_MASK    = 16'hffff;
	localparam logic [15:0] GAINS_MASK      = 16'h003f;

	// field positions
	localparam int          ORDER_LSB       = 0;
	localparam int          WIDTH_LSB       = 11;
	localparam int          WIDTH_W         = 5;
	localparam int          DELAY_LSB       = 0;
	localparam int          DELAY_W         = 11;
	localparam int          MODE_LSB        = 10;
	localparam int          INTG_LSB        = 8;
	localparam int          BUF_BIT         = 7;
	localparam int          IND_BIT         = 6;
	localparam int          VREF_LSB        = 4;
	localparam int          COMMON_LSB      = 0;
	localparam int          CH4_LSB         = 4;
	localparam int          CH3_LSB         = 2;
	localparam int          CH2_LSB         = 0;

	// integrator gain codes
	localparam logic [1:0]  INTG_400K       = 2'h0;
	localparam logic [1:0]  INTG_200K       = 2'h1;
	localparam logic [1:0]  INTG_100K       = 2'h2;

	// timing: clock period and field step sizes in picoseconds, width step also in clock cycles
	localparam int          CLK_PERIOD_PS   = 4000;
	localparam int          DELAY_STEP_PS   = 31250;
	localparam int          WIDTH_STEP_PS   = 1000000;
	localparam int          WIDTH_STEP_CYC  = WIDTH_STEP_PS / CLK_PERIOD_PS;

	// configuration handed to the analog front end
	typedef struct packed {
		logic [5:0] frontend_mode;     // mode field, passed through
		logic [1:0] vref;              // amplifier reference select
		logic [1:0] ch1_gain;          // 0:200k 1:100k 2:50k 3:25k
		logic [1:0] ch2_gain;
		logic [1:0] ch3_gain;
		logic [1:0] ch4_gain;
		logic       integrator_buffer; // integrator runs as buffer
		logic [2:0] rint_sel;          // one-hot 400k/200k/100k, normal mode only
		logic       buffer_gain_low;   // buffer gain 0.7 instead of 1.0
	} afe_cfg_s;

endpackage
`default_nettype wire

/* rtl/polarity_sequencer.sv */
// per-pulse integration polarity from a four-entry pattern
`default_nettype none
module polarity_sequencer
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// pulse timing
	input  wire logic       slot_start,
	input  wire logic       pulse_start,
	// pattern, bit n for pulse n+1
	input  wire logic [3:0] pattern,
	// polarity of the current pulse
	output var  logic       pulse_reverse,
	output var  logic [1:0] pulse_index
);

	logic [1:0] next_index;   // entry that the coming pulse uses
	logic [1:0] cur_index;    // entry used by this pulse

	// a slot start rewinds the pattern, even in the cycle of a pulse
	always_comb
	begin
		cur_index = slot_start ? 2'h0 : next_index;
	end

	// step through the pattern, wrapping after the fourth pulse
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			next_index    <= 2'h0;
			pulse_reverse <= 1'b0;
			pulse_index   <= 2'h0;
		end
		else if (pulse_start)
		begin
			pulse_reverse <= pattern[cur_index];
			pulse_index   <= cur_index;
			next_index    <= cur_index + 2'h1;
		end
		else if (slot_start)
		begin
			next_index    <= 2'h0;
		end
	end

endmodule
`default_nettype wire

/* verif/slot_a_afe_config_regs_asserts.sv */
// checker for the slot a front-end register bank
`default_nettype none
module slot_a_afe_config_regs_asserts
#(
	parameter int ADDR_W = 12	// apb address width
)
(
	// clock and reset
	input wire logic	clk_sys,
	input wire logic	rstn,
	// apb slave
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [3:0]	pstrb,
	input wire logic	pready,
	input wire logic [31:0]	prdata,
	input wire logic	pslverr,
	// slot timing
	input wire logic	slot_start,
	input wire logic	pulse_start,
	input wire logic	window_open,
	input wire logic	pulse_reverse,
	input wire logic [1:0]	pulse_index,
	// front-end configuration
	input wire afe_cfg_pkg::afe_cfg_s	afe_cfg
);
	logic	mapped;	// address hits one of the four words
	logic	seen;	// pattern pointer has left entry 0 in this slot
	assign mapped = paddr inside {'h5c, 'he4, 'h108, 'h154};
	// track whether the next pulse must step on from the last index
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || (slot_start && !pulse_start))
			seen <= 1'b0;
		else if (pulse_start)
			seen <= 1'b1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_bad_read;
		psel && !penable && !pwrite && !mapped;
	endsequence
	a_err_unmapped: assert property (pslverr == (psel && penable && !mapped))
		else $error("error response mismatch");
	a_zero_wait: assert property (s_access |-> pready)
		else $error("access phase not ready");
	a_unmapped_zero: assert property (s_bad_read |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (prdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	a_rint_onehot: assert property ($past(rstn) && !afe_cfg.integrator_buffer
		|-> $onehot(afe_cfg.rint_sel)) else $error("resistor select not one-hot");
	a_buffer_rint: assert property (afe_cfg.integrator_buffer |-> afe_cfg.rint_sel == 3'h0)
		else $error("resistor selected in buffer mode");
	a_low_needs_buf: assert property (afe_cfg.buffer_gain_low |-> afe_cfg.integrator_buffer)
		else $error("low buffer gain outside buffer mode");
	a_slot_rewind: assert property (pulse_start && slot_start |=> pulse_index == 2'h0)
		else $error("slot start did not rewind pattern");
	a_step_index: assert property (pulse_start && !slot_start && seen
		|=> pulse_index == $past(pulse_index) + 2'h1) else $error("pattern index did not step");
	a_hold_polarity: assert property (!pulse_start
		|=> $stable(pulse_reverse) && $stable(pulse_index)) else $error("polarity moved");
endmodule
bind slot_a_afe_config_regs slot_a_afe_config_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_sys,
	.rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
	.slot_start, .pulse_start, .window_open, .pulse_reverse, .pulse_index, .afe_cfg);
`default_nettype wire

/* verif/test_slot_a_afe_config_regs.sv */
// self-checking bench for the slot a front-end register bank
`default_nettype none
module test_slot_a_afe_config_regs;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus
	logic	clk_sys = 1'b0;
	logic	rstn = 1'b0;
	logic	psel = 1'b0;
	logic	penable = 1'b0;
	logic	pwrite = 1'b0;
	logic [11:0]	paddr = 12'h0;
	logic [31:0]	pwdata = 32'h0;
	logic [3:0]	pstrb = 4'hf;
	logic	slot_start = 1'b0;
	logic	pulse_start = 1'b0;
	// design outputs
	logic	pready;
	logic [31:0]	prdata;
	logic	pslverr;
	logic	window_open;
	logic	pulse_reverse;
	logic [1:0]	pulse_index;
	afe_cfg_pkg::afe_cfg_s	afe_cfg;
	// bookkeeping
	int	error_cnt = 0;
	int	samples_checked = 0;
	logic [31:0]	rd;	// last read data
	logic	err;	// last error response
	int	n;	// cycles to window start
	int	m;	// cycles window stayed open
	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;
	slot_a_afe_config_regs #(.ADDR_W(12)) DUT (.clk_sys, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .slot_start, .pulse_start,
		.window_open, .pulse_reverse, .pulse_index, .afe_cfg);
	// one edge, then let its updates land
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	// compare one value with its expectation
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer to register index idx; drives on the edge, waits for pready however long
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one-cycle pulse on the timing inputs, driven on the edge; returns once outputs settle
	task automatic pulse(input logic slot, input logic led);
		@(posedge clk_sys);
		slot_start <= slot;
		pulse_start <= led;
		@(posedge clk_sys);
		slot_start <= 1'b0;
		pulse_start <= 1'b0;
		#1;
	endtask
	// program the window, fire a pulse and time it
	task automatic win(input logic [10:0] dly, input logic [4:0] wid);
		apb(1'b1, 10'h39, {wid, dly});
		pulse(1'b0, 1'b1);
		for (n = 0; window_open !== 1'b1 && n < 9000; n++)
			tick();
		chk(n, (dly * 31250 + 3999) / 4000);
		for (m = 0; window_open === 1'b1 && m < 9000; m++)
			tick();
		chk(m, wid * 250);
	endtask
	// control word with mode 0x07 and the reserved pair at 0x1
	function automatic logic [15:0] ctl(input logic [1:0] ig, input logic bf, input logic ind,
		input logic [1:0] g);
		return {6'h07, ig, bf, ind, 2'h3, 2'h1, g};
	endfunction
	// verdict
	task automatic end_sim();
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		tick();
		chk(afe_cfg.frontend_mode, 32'h7);
		chk(afe_cfg.rint_sel, 32'h1);
		apb(1'b0, 10'h39, 16'h0);
		chk(rd, {16'h0, 5'h04, 11'h2fc});
		// upper byte lane only: the low byte keeps its reset value
		pstrb <= 4'h2;
		apb(1'b1, 10'h39, 16'hffff);
		pstrb <= 4'hf;
		apb(1'b0, 10'h39, 16'h0);
		chk(rd, 32'hfffc);
		apb(1'b0, 10'h42, 16'h0);
		chk(rd, afe_cfg_pkg::CONTROL_RST);
		apb(1'b0, 10'h55, 16'h0);
		chk(rd, 32'h0);
		apb(1'b1, 10'h17, 16'hffff);
		apb(1'b0, 10'h17, 16'h0);
		chk(rd, 32'hf);
		apb(1'b1, 10'h20, 16'h1234);
		chk(err, 1'b1);
		apb(1'b0, 10'h20, 16'h0);
		chk(rd, 32'h0);
		// shared gain first, then own gains, every code
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, 10'h42, ctl(2'h0, 1'b0, 1'b0, 2'(k)));
			apb(1'b1, 10'h55, {10'h0, 2'(k + 2), 2'(3 - k), 2'(k ^ 1)});
			tick();
			chk(afe_cfg.ch2_gain, k);
			chk(afe_cfg.ch3_gain, k);
			chk(afe_cfg.ch4_gain, k);
			apb(1'b1, 10'h42, ctl(2'h0, 1'b0, 1'b1, 2'(k)));
			tick();
			chk(afe_cfg.ch1_gain, k);
			chk(afe_cfg.ch2_gain, k ^ 1);
			chk(afe_cfg.ch3_gain, 3 - k);
			chk(afe_cfg.ch4_gain, (k + 2) % 4);
		end
		// every integrator code in normal and buffer mode
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, 10'h42, ctl(2'(k), k[2], 1'b0, 2'h0));
			tick();
			chk(afe_cfg.integrator_buffer, k[2]);
			chk(afe_cfg.rint_sel, k[2] ? 0 : (k[1:0] == 0 ? 1 : (k[1:0] == 1 ? 2 : 4)));
			chk(afe_cfg.buffer_gain_low, k == 6);
		end
		// pattern 1101 across six pulses, then a rewind
		apb(1'b1, 10'h17, 16'h000d);
		pulse(1'b1, 1'b1);
		for (int k = 0; k < 6; k++)
		begin
			chk(pulse_index, k % 4);
			chk(pulse_reverse, (13 >> (k % 4)) & 1);
			pulse(1'b0, 1'b1);
		end
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk(pulse_index, 32'h0);
		chk(pulse_reverse, 32'h1);
		// window delay and width, including no delay
		win(11'h1, 5'h1);
		win(11'h3, 5'h2);
		win(11'h0, 5'h1);
		end_sim();
	end
	// watchdog
	initial
	begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule
`default_nettype wire
